// *** rtl/wdpr_cfg.svh ***
`ifndef WDPR_CFG_SVH
`define WDPR_CFG_SVH

// ============================================================
// Register map: word indices, byte address is four times the index
`define WDPR_POWER_CONTROL_REG_IDX       12'h087
`define WDPR_WATCHDOG_CONTROL_REG_IDX       12'h08F
`define WDPR_STAT_IDX       12'h090
`define WDPR_ADDR_W         12
`define WDPR_WORD_SHIFT     2

// ============================================================
// Reset values
`define WDPR_SFR_RST        8'h00
`define WDPR_PORT_RST       8'hFF
`define WDPR_SP_RST         8'h07

// ============================================================
// Machine timing
`define WDPR_STATES_PER_MC  3'h6
`define WDPR_SAMPLE_STATE   3'h4
`define WDPR_LAST_STATE     3'h5
`define WDPR_PRESC_W        8
`define WDPR_TIMER_W        14
`define WDPR_FILT_LEN       3
`define WDPR_WDR_MC         2'h2

// ============================================================
// Bus answers
`define WDPR_RESP_OKAY      2'h0
`define WDPR_RESP_SLVERR    2'h2

`endif

// *** rtl/wdpr_pkg.sv ***
package wdpr_pkg;

    // ============================================================
    // Register layouts
    typedef struct packed {
        logic       wdog_enable;
        logic       wdog_restart;
        logic       wdog_run_in_sleep;
        logic [1:0] unused;
        logic [2:0] wdog_prescale_sel;
    } wdpr_watchdog_control_reg_type;

    typedef struct packed {
        logic [2:0] unused;
        logic       cold_boot_flag;
        logic       user_flag_1;
        logic       user_flag_0;
        logic       power_down_request;
        logic       sleep_core_request;
    } wdpr_power_control_reg_type;

    // ============================================================
    // AXI4-Lite channels
    typedef struct packed {
        logic [11:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [11:0] araddr;
        logic        arvalid;
        logic        rready;
    } wdpr_axi_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } wdpr_axi_rsp_type;

    typedef enum logic [1:0] {
        WDPR_RQ_IDLE,
        WDPR_RQ_ONE,
        WDPR_RQ_ACTIVE
    } wdpr_rq_state_type;

endpackage

// *** rtl/wdpr_top.sv ***
`timescale 1ns/100ps
`include "wdpr_cfg.svh"

module wdpr_top
    import wdpr_pkg::*;
#(
    parameter int TIMER_BITS = `WDPR_TIMER_W
) (
    // Clock and power-on reset
    input  wire logic             core_clk,
    input  wire logic             nrst,
    // Register bus
    input  wire wdpr_axi_req_type axi_req,
    output wdpr_axi_rsp_type      axi_rsp,
    // Reset pin and interrupt request
    input  wire logic             rst_pin,
    input  wire logic             irq_pending,
    // Clock control and system reset
    output logic                  half_clk,
    output logic                  core_clk_en,
    output logic                  periph_clk_en,
    output logic                  osc_en,
    output logic                  sys_reset,
    output logic [7:0]            port_reset_val,
    output logic [7:0]            stack_reset_val
);

    if (TIMER_BITS < 2 || TIMER_BITS > `WDPR_TIMER_W) begin
        $error("TIMER_BITS out of range");
    end

    localparam logic [11:0] POWER_CONTROL_REG_ADDR = `WDPR_POWER_CONTROL_REG_IDX << `WDPR_WORD_SHIFT;
    localparam logic [11:0] WATCHDOG_CONTROL_REG_ADDR = `WDPR_WATCHDOG_CONTROL_REG_IDX << `WDPR_WORD_SHIFT;
    localparam logic [11:0] STAT_ADDR = `WDPR_STAT_IDX << `WDPR_WORD_SHIFT;

    // ============================================================
    // Machine timing from the halved oscillator
    logic [2:0] state_cnt;
    logic       mc_tick;
    logic       sample_pt;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            half_clk <= 1'b0;
        end else begin
            half_clk <= ~half_clk;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_cnt <= 3'h0;
        end else if (half_clk) begin
            state_cnt <= (state_cnt == `WDPR_LAST_STATE) ? 3'h0 : state_cnt + 3'h1;
        end
    end

    assign mc_tick   = half_clk && (state_cnt == `WDPR_LAST_STATE);
    assign sample_pt = half_clk && (state_cnt == `WDPR_SAMPLE_STATE);

    // ============================================================
    // Reset pin filter and qualifier
    // The filter has hysteresis: it flips only on a full run of equal samples.
    logic [`WDPR_FILT_LEN-1:0] filt_hist;
    logic                      rst_filt;
    wdpr_rq_state_type         rq_state;
    logic                      pin_reset_active;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            filt_hist <= '0;
        end else begin
            filt_hist <= {filt_hist[`WDPR_FILT_LEN-2:0], rst_pin};
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_filt <= 1'b0;
        end else if (&filt_hist) begin
            rst_filt <= 1'b1;
        end else if (~|filt_hist) begin
            rst_filt <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rq_state <= WDPR_RQ_IDLE;
        end else if (sample_pt) begin
            unique case (rq_state)
                WDPR_RQ_IDLE:   rq_state <= rst_filt ? WDPR_RQ_ONE : WDPR_RQ_IDLE;
                WDPR_RQ_ONE:    rq_state <= rst_filt ? WDPR_RQ_ACTIVE : WDPR_RQ_IDLE;
                WDPR_RQ_ACTIVE: rq_state <= rst_filt ? WDPR_RQ_ACTIVE : WDPR_RQ_IDLE;
                default:        rq_state <= WDPR_RQ_IDLE;
            endcase
        end
    end

    assign pin_reset_active = (rq_state == WDPR_RQ_ACTIVE);

    // ============================================================
    // Registers and watchdog counters
    wdpr_watchdog_control_reg_type         watchdog_control_reg;
    wdpr_power_control_reg_type         power_control_reg;
    logic [7:0]            presc;
    logic [TIMER_BITS-1:0] timer;
    logic [7:0]            presc_top;
    logic                  wdog_run;
    logic                  presc_wrap;
    logic                  wdt_timeout;
    logic                  wdt_reset_active;
    logic [1:0]            wdr_cnt;
    logic                  restart_clr;
    logic                  wr_power_control_reg;
    logic                  wr_watchdog_control_reg;
    wdpr_watchdog_control_reg_type         wr_watchdog_control_reg_val;
    wdpr_power_control_reg_type         wr_power_control_reg_val;

    assign sys_reset     = pin_reset_active | wdt_reset_active;
    assign core_clk_en   = !power_control_reg.sleep_core_request && !power_control_reg.power_down_request;
    assign periph_clk_en = !power_control_reg.power_down_request;
    assign osc_en        = !power_control_reg.power_down_request;

    assign presc_top   = 8'((9'h002 << watchdog_control_reg.wdog_prescale_sel) - 9'h001);
    assign wdog_run    = watchdog_control_reg.wdog_enable && !power_control_reg.power_down_request
                         && (!power_control_reg.sleep_core_request || watchdog_control_reg.wdog_run_in_sleep);
    assign restart_clr = mc_tick && watchdog_control_reg.wdog_restart;
    assign presc_wrap  = mc_tick && wdog_run && (presc == presc_top);
    assign wdt_timeout = presc_wrap && (&timer) && !restart_clr;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            presc <= '0;
        end else if (sys_reset || restart_clr) begin
            presc <= '0;
        end else if (mc_tick && wdog_run) begin
            presc <= presc_wrap ? 8'h00 : presc + 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            timer <= '0;
        end else if (sys_reset || restart_clr) begin
            timer <= '0;
        end else if (presc_wrap) begin
            timer <= timer + 1'b1;
        end
    end

    // A time-out holds the system in reset for a few machine cycles.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wdt_reset_active <= 1'b0;
            wdr_cnt          <= 2'h0;
        end else if (wdt_timeout) begin
            wdt_reset_active <= 1'b1;
            wdr_cnt          <= `WDPR_WDR_MC;
        end else if (mc_tick && wdt_reset_active) begin
            wdr_cnt          <= wdr_cnt - 2'h1;
            wdt_reset_active <= (wdr_cnt != 2'h1);
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            watchdog_control_reg <= wdpr_watchdog_control_reg_type'(`WDPR_SFR_RST);
        end else if (sys_reset) begin
            watchdog_control_reg <= wdpr_watchdog_control_reg_type'(`WDPR_SFR_RST);
        end else begin
            if (wr_watchdog_control_reg) begin
                watchdog_control_reg.wdog_enable       <= wr_watchdog_control_reg_val.wdog_enable;
                watchdog_control_reg.wdog_run_in_sleep <= wr_watchdog_control_reg_val.wdog_run_in_sleep;
                watchdog_control_reg.wdog_prescale_sel <= wr_watchdog_control_reg_val.wdog_prescale_sel;
            end
            // A fresh write of one beats the self-clear.
            if (wr_watchdog_control_reg && wr_watchdog_control_reg_val.wdog_restart) begin
                watchdog_control_reg.wdog_restart <= 1'b1;
            end else if (restart_clr) begin
                watchdog_control_reg.wdog_restart <= 1'b0;
            end
        end
    end

    // Each power control field is its own flop so that every process owns its targets.
    logic       cold_flag;
    logic [1:0] user_flags;
    logic       pd_req;
    logic       idle_req;

    assign power_control_reg = '{unused: 3'h0, cold_boot_flag: cold_flag, user_flag_1: user_flags[1],
                    user_flag_0: user_flags[0], power_down_request: pd_req,
                    sleep_core_request: idle_req};

    // Cold boot flag is set by the power-on reset or by a register write; system reset keeps it.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cold_flag <= 1'b1;
        end else if (wr_power_control_reg) begin
            cold_flag <= wr_power_control_reg_val.cold_boot_flag;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            user_flags <= 2'h0;
            pd_req     <= 1'b0;
        end else if (sys_reset) begin
            user_flags <= 2'h0;
            pd_req     <= 1'b0;
        end else if (wr_power_control_reg) begin
            user_flags <= {wr_power_control_reg_val.user_flag_1, wr_power_control_reg_val.user_flag_0};
            pd_req     <= pd_req | wr_power_control_reg_val.power_down_request;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            idle_req <= 1'b0;
        end else if (sys_reset || irq_pending) begin
            idle_req <= 1'b0;
        end else if (wr_power_control_reg) begin
            idle_req <= wr_power_control_reg_val.sleep_core_request;
        end
    end

    // Ports and stack pointer live elsewhere; these give their reset loads.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            port_reset_val  <= `WDPR_PORT_RST;
            stack_reset_val <= `WDPR_SP_RST;
        end else if (sys_reset) begin
            port_reset_val  <= `WDPR_PORT_RST;
            stack_reset_val <= `WDPR_SP_RST;
        end
    end

    // ============================================================
    // AXI4-Lite slave
    logic        aw_held;
    logic [11:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic        w_lane0;
    logic        do_write;
    logic        write_hit;
    logic        b_valid;
    logic [1:0]  b_resp;
    logic        r_valid;
    logic [31:0] r_data;
    logic [1:0]  r_resp;

    assign axi_rsp = '{awready: !aw_held && !b_valid, wready: !w_held && !b_valid,
                       bresp: b_resp, bvalid: b_valid, arready: !r_valid,
                       rdata: r_data, rresp: r_resp, rvalid: r_valid};
    assign do_write        = aw_held && w_held && !b_valid;
    assign write_hit       = (aw_addr == POWER_CONTROL_REG_ADDR) || (aw_addr == WATCHDOG_CONTROL_REG_ADDR)
                             || (aw_addr == STAT_ADDR);
    assign wr_power_control_reg         = do_write && w_lane0 && (aw_addr == POWER_CONTROL_REG_ADDR);
    assign wr_watchdog_control_reg         = do_write && w_lane0 && (aw_addr == WATCHDOG_CONTROL_REG_ADDR);
    assign wr_power_control_reg_val     = wdpr_power_control_reg_type'(w_data[7:0]);
    assign wr_watchdog_control_reg_val     = wdpr_watchdog_control_reg_type'(w_data[7:0]);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            aw_held <= 1'b0;
            aw_addr <= 12'h000;
        end else if (axi_req.awvalid && axi_rsp.awready) begin
            aw_held <= 1'b1;
            aw_addr <= axi_req.awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            w_held  <= 1'b0;
            w_data  <= 32'h0000_0000;
            w_lane0 <= 1'b0;
        end else if (axi_req.wvalid && axi_rsp.wready) begin
            w_held  <= 1'b1;
            w_data  <= axi_req.wdata;
            w_lane0 <= axi_req.wstrb[0];
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            b_valid <= 1'b0;
            b_resp  <= `WDPR_RESP_OKAY;
        end else if (do_write) begin
            b_valid <= 1'b1;
            b_resp  <= write_hit ? `WDPR_RESP_OKAY : `WDPR_RESP_SLVERR;
        end else if (axi_req.bready) begin
            b_valid <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            r_valid <= 1'b0;
            r_data  <= 32'h0000_0000;
            r_resp  <= `WDPR_RESP_OKAY;
        end else if (axi_req.arvalid && !r_valid) begin
            r_valid <= 1'b1;
            r_resp  <= `WDPR_RESP_OKAY;
            unique case (axi_req.araddr)
                POWER_CONTROL_REG_ADDR: r_data <= {24'h000000, power_control_reg};
                WATCHDOG_CONTROL_REG_ADDR: r_data <= {24'h000000, watchdog_control_reg};
                STAT_ADDR: r_data <= {5'h00, sys_reset, power_control_reg.power_down_request,
                                      power_control_reg.sleep_core_request, presc, 16'(timer)};
                default: begin
                    r_data <= 32'h0000_0000;
                    r_resp <= `WDPR_RESP_SLVERR;
                end
            endcase
        end else if (axi_req.rready) begin
            r_valid <= 1'b0;
        end
    end

    // ============================================================
    // Assertions
    sequence s_high_sample;
        sample_pt && rst_filt;
    endsequence

    sequence s_restart_due;
        watchdog_control_reg.wdog_restart && mc_tick && !sys_reset && !(wr_watchdog_control_reg && wr_watchdog_control_reg_val.wdog_restart);
    endsequence

    a_restart_clears: assert property (
        @(posedge core_clk) disable iff (!nrst)
        s_restart_due |=> (timer == '0) && (presc == 8'h00) && !watchdog_control_reg.wdog_restart)
        else $error("restart did not clear the watchdog");

    a_restart_selfclr: assert property (
        @(posedge core_clk) disable iff (!nrst)
        $rose(watchdog_control_reg.wdog_restart) |-> ##[1:13] !watchdog_control_reg.wdog_restart)
        else $error("restart bit stuck");

    a_disabled_quiet: assert property (
        @(posedge core_clk) disable iff (!nrst)
        !watchdog_control_reg.wdog_enable |=> $stable(timer) || (timer == '0))
        else $error("disabled watchdog counted");

    a_idle_stops_wdog: assert property (
        @(posedge core_clk) disable iff (!nrst)
        power_control_reg.sleep_core_request && !watchdog_control_reg.wdog_run_in_sleep |-> !presc_wrap)
        else $error("watchdog ran in idle");

    a_timer_step: assert property (
        @(posedge core_clk) disable iff (!nrst)
        presc_wrap && !restart_clr && !sys_reset |=> timer == $past(timer) + 1'b1)
        else $error("timer missed a prescaler wrap");

    a_timeout_resets: assert property (
        @(posedge core_clk) disable iff (!nrst)
        wdt_timeout |=> sys_reset ##1 !watchdog_control_reg.wdog_enable)
        else $error("time-out gave no reset");

    a_reset_disables: assert property (
        @(posedge core_clk) disable iff (!nrst)
        sys_reset |=> !watchdog_control_reg.wdog_enable && (timer == '0) && (presc == 8'h00))
        else $error("reset left watchdog running");

    a_idle_gates_core: assert property (
        @(posedge core_clk) disable iff (!nrst)
        power_control_reg.sleep_core_request && !power_control_reg.power_down_request |-> !core_clk_en && periph_clk_en)
        else $error("idle clock gating wrong");

    a_idle_exit: assert property (
        @(posedge core_clk) disable iff (!nrst)
        (irq_pending || sys_reset) |=> !power_control_reg.sleep_core_request && !power_control_reg.power_down_request
            || !sys_reset && $past(power_control_reg.power_down_request))
        else $error("idle not left on interrupt or reset");

    a_pd_only_reset: assert property (
        @(posedge core_clk) disable iff (!nrst)
        power_control_reg.power_down_request && !sys_reset |=> power_control_reg.power_down_request && !osc_en)
        else $error("power-down ended without reset");

    a_cold_flag_kept: assert property (
        @(posedge core_clk) disable iff (!nrst)
        power_control_reg.cold_boot_flag && !wr_power_control_reg |=> power_control_reg.cold_boot_flag)
        else $error("cold boot flag lost");

    a_pin_two_mc: assert property (
        @(posedge core_clk) disable iff (!nrst)
        s_high_sample ##12 s_high_sample |=> pin_reset_active)
        else $error("held reset pin not taken");

    a_half_clock: assert property (
        @(posedge core_clk) disable iff (!nrst)
        half_clk |=> !half_clk ##1 half_clk)
        else $error("internal clock not halved");

endmodule

// *** test/wdpr_top_tb.sv ***
`timescale 1ns/100ps
`include "wdpr_cfg.svh"

module wdpr_top_tb
    import wdpr_pkg::*;
;
    // ============================================================
    // Setup
    // A short timer keeps each time-out within a few thousand clocks.
    localparam int          TB     = 4;
    localparam logic [11:0] A_POWER_CONTROL_REG = `WDPR_POWER_CONTROL_REG_IDX << `WDPR_WORD_SHIFT;
    localparam logic [11:0] A_WATCHDOG_CONTROL_REG = `WDPR_WATCHDOG_CONTROL_REG_IDX << `WDPR_WORD_SHIFT;
    localparam logic [11:0] A_STAT = `WDPR_STAT_IDX << `WDPR_WORD_SHIFT;
    localparam logic [1:0]  OK     = `WDPR_RESP_OKAY;
    localparam logic [1:0]  SERR   = `WDPR_RESP_SLVERR;

    logic             core_clk;
    logic             nrst;
    logic             rst_pin;
    logic             irq_pending;
    wdpr_axi_req_type req;
    wdpr_axi_rsp_type rsp;
    logic             half_clk;
    logic             core_clk_en;
    logic             periph_clk_en;
    logic             osc_en;
    logic             sys_reset;
    logic [7:0]       port_reset_val;
    logic [7:0]       stack_reset_val;
    int               err_count;
    int               n_compared;
    int               cyc;
    logic [31:0]      d;
    logic             hc;

    always #4 core_clk = ~core_clk;

    wdpr_top #(.TIMER_BITS(TB)) u_dut (
        .core_clk       (core_clk),
        .nrst           (nrst),
        .axi_req        (req),
        .axi_rsp        (rsp),
        .rst_pin        (rst_pin),
        .irq_pending    (irq_pending),
        .half_clk       (half_clk),
        .core_clk_en    (core_clk_en),
        .periph_clk_en  (periph_clk_en),
        .osc_en         (osc_en),
        .sys_reset      (sys_reset),
        .port_reset_val (port_reset_val),
        .stack_reset_val(stack_reset_val)
    );

    // ============================================================
    // Helpers
    task automatic print_verdict();
        $display("Compared %0d, errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic bail(input string nm);
        err_count++;
        $display("[ERR] %s expected done seen timeout", nm);
        print_verdict();
    endtask

    // Address and data are offered together; each drops once taken.
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge core_clk);
        req.awaddr <= a;
        req.awvalid <= 1'b1;
        req.wdata <= v;
        req.wstrb <= 4'hF;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid && n < 100);
        req.bready <= 1'b0;
        if (n >= 100) bail("write");
        chk("bresp", {30'h0, er}, {30'h0, rsp.bresp});
    endtask

    task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] v);
        int n;
        n = 0;
        @(posedge core_clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid && n < 100);
        req.rready <= 1'b0;
        if (n >= 100) bail("read");
        v = rsp.rdata;
        chk("rresp", {30'h0, er}, {30'h0, rsp.rresp});
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, OK, v);
        chk("rdata", exp, v);
    endtask

    task automatic wait_rst(input logic lvl, input int lim);
        cyc = 0;
        while (sys_reset !== lvl && cyc < lim) begin
            @(posedge core_clk);
            cyc++;
        end
        if (sys_reset !== lvl) bail("sys_reset");
    endtask

    task automatic quiet(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge core_clk);
            seen = seen | sys_reset;
        end
        chk("no_reset", 32'h0, {31'h0, seen});
    endtask

    // Start of counting trails the register write by up to one machine cycle.
    task automatic near(input string nm, input int exp, input int got);
        chk(nm, 32'h1, {31'h0, (got >= exp - 24 && got <= exp + 24)});
    endtask

    // ============================================================
    // Sequence
    initial begin
        core_clk = 1'b0;
        nrst = 1'b0;
        rst_pin = 1'b0;
        irq_pending = 1'b0;
        req = '0;
        err_count = 0;
        n_compared = 0;
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        chk("port_rst", 32'hFF, {24'h0, port_reset_val});
        chk("stack_rst", 32'h07, {24'h0, stack_reset_val});
        rdc(A_POWER_CONTROL_REG, 32'h10);
        rdc(A_WATCHDOG_CONTROL_REG, 32'h00);
        rdc(A_STAT, 32'h00);
        rd(12'h100, SERR, d);
        chk("unmapped", 32'h0, d);
        wr(12'h100, 32'hFF, SERR);
        repeat (4) begin
            hc = half_clk;
            @(posedge core_clk);
            chk("half_clk", {31'h0, ~hc}, {31'h0, half_clk});
        end
        wr(A_POWER_CONTROL_REG, 32'h1C, OK);
        rdc(A_POWER_CONTROL_REG, 32'h1C);
        quiet(500);
        rdc(A_STAT, 32'h0);
        wr(A_WATCHDOG_CONTROL_REG, 32'h80, OK);
        repeat (200) @(posedge core_clk);
        wr(A_WATCHDOG_CONTROL_REG, 32'hC0, OK);
        d = 32'h40;
        for (int i = 0; i < 8 && d[6]; i++) rd(A_WATCHDOG_CONTROL_REG, OK, d);
        chk("watchdog_control_reg", 32'h80, d);
        rdc(A_STAT, 32'h0);
        wr(A_WATCHDOG_CONTROL_REG, 32'h00, OK);
        quiet(500);
        for (int s = 0; s < 8; s++) begin
            wr(A_WATCHDOG_CONTROL_REG, 32'h80 | s, OK);
            rdc(A_WATCHDOG_CONTROL_REG, 32'h80 | s);
            if (s < 4) begin
                wait_rst(1'b1, 4000);
                near("timeout", (12 << TB) << (s + 1), cyc + 4);
                wait_rst(1'b0, 100);
                rdc(A_WATCHDOG_CONTROL_REG, 32'h0);
                rdc(A_POWER_CONTROL_REG, 32'h10);
            end
        end
        wr(A_WATCHDOG_CONTROL_REG, 32'hC0, OK);
        wr(A_POWER_CONTROL_REG, 32'h11, OK);
        @(posedge core_clk);
        chk("clk_en", 32'h3, {29'h0, core_clk_en, periph_clk_en, osc_en});
        quiet(800);
        irq_pending <= 1'b1;
        repeat (3) @(posedge core_clk);
        irq_pending <= 1'b0;
        chk("core_en", 32'h1, {31'h0, core_clk_en});
        rdc(A_POWER_CONTROL_REG, 32'h10);
        wr(A_WATCHDOG_CONTROL_REG, 32'hE0, OK);
        wr(A_POWER_CONTROL_REG, 32'h11, OK);
        wait_rst(1'b1, 1000);
        near("idle_timeout", 12 << (TB + 1), cyc + 4);
        @(posedge core_clk);
        chk("core_en", 32'h1, {31'h0, core_clk_en});
        wait_rst(1'b0, 100);
        wr(A_POWER_CONTROL_REG, 32'h12, OK);
        @(posedge core_clk);
        chk("clk_en", 32'h0, {29'h0, core_clk_en, periph_clk_en, osc_en});
        irq_pending <= 1'b1;
        repeat (40) @(posedge core_clk);
        irq_pending <= 1'b0;
        chk("osc_en", 32'h0, {31'h0, osc_en});
        rst_pin <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst_pin <= 1'b0;
        quiet(40);
        rst_pin <= 1'b1;
        wait_rst(1'b1, 40);
        rst_pin <= 1'b0;
        wait_rst(1'b0, 40);
        chk("osc_en", 32'h1, {31'h0, osc_en});
        rdc(A_POWER_CONTROL_REG, 32'h10);
        wr(A_POWER_CONTROL_REG, 32'h08, OK);
        rst_pin <= 1'b1;
        wait_rst(1'b1, 40);
        rst_pin <= 1'b0;
        wait_rst(1'b0, 40);
        rdc(A_POWER_CONTROL_REG, 32'h00);
        print_verdict();
    end
endmodule
